// File: design/safety_gate_pkg.sv
// safety gate monitor: register map, field positions, reset values, timing
// assumes a single 25 MHz clock and an APB register bus
`default_nettype none

package safety_gate_pkg;

    // ------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_OUTEN = 8'h04;
    localparam logic [7:0] OFS_DISC1 = 8'h08;
    localparam logic [7:0] OFS_DISC2 = 8'h0c;
    localparam logic [7:0] OFS_SYNC = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_TYPE_LSB = 0;
    localparam int CTRL_FTEST_BIT = 3;
    localparam int CTRL_RUN_BIT = 4;
    localparam int EN_DISC_LSB = 0;
    localparam int EN_FTREQ_BIT = 2;
    localparam int EN_SYNC_BIT = 3;
    localparam int EN_FTERR_BIT = 4;
    localparam int EN_FAULT_BIT = 5;
    localparam int ST_OE_BIT = 0;
    localparam int ST_FAULT_BIT = 1;
    localparam int ST_DISC_LSB = 2;
    localparam int ST_SYNC_BIT = 4;
    localparam int ST_FTERR_BIT = 5;
    localparam int ST_FTREQ_BIT = 6;
    localparam int ST_RUN_BIT = 7;
    localparam int ST_GATE_LSB = 8;
    localparam int ST_REQ_BIT = 12;

    // ------------------------------------------------------------
    // timing: settings count 10 ms steps
    // ------------------------------------------------------------
    localparam int TIME_W = 12;
    localparam int CLK_HZ = 25_000_000;
    localparam int STEP_MS = 10;
    localparam int STEP_CYCLES = CLK_HZ / 1000 * STEP_MS;
    localparam int SCAN_US = 100;
    localparam int SCAN_CYCLES = CLK_HZ / 1_000_000 * SCAN_US;
    localparam int DISC_DEF_MS = 30;
    localparam int SYNC_DEF_MS = 300;
    localparam logic [TIME_W-1:0] DISC_RST = TIME_W'(DISC_DEF_MS / STEP_MS);
    localparam logic [TIME_W-1:0] SYNC_RST = TIME_W'(SYNC_DEF_MS / STEP_MS);
    localparam logic [5:0] OUTEN_RST = 6'h3f;

    // input configurations
    typedef enum logic [2:0] {IN_SINGLE, IN_EQV1, IN_CMP1, IN_EQV2, IN_CMP2} in_type_t;

endpackage : safety_gate_pkg

`default_nettype wire

// File: design/scan_ticker.sv
// scan_ticker: controller-cycle enable and 10 ms step enable
// assumes both periods are at least two clocks
`default_nettype none

module scan_ticker #(
    parameter int SCAN_CYC = 2500,
    parameter int STEP_CYC = 250000
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // enables
    output logic scan_en,
    output logic step_en
);
    localparam int SW = $clog2(SCAN_CYC);
    localparam int TW = $clog2(STEP_CYC);
    logic [SW-1:0] scan_q;
    logic [TW-1:0] step_q;

    // free-running dividers, one pulse per wrap
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scan_q <= '0;
            step_q <= '0;
        end
        else
        begin
            scan_q <= scan_en ? '0 : scan_q + 1'b1;
            step_q <= step_en ? '0 : step_q + 1'b1;
        end
    end

    assign scan_en = (scan_q == SW'(SCAN_CYC - 1));
    assign step_en = (step_q == TW'(STEP_CYC - 1));

endmodule : scan_ticker

`default_nettype wire

// File: design/hold_timer.sv
// hold_timer: counts 10 ms steps while a condition lasts
// assumes the limit register is stable while counting
`default_nettype none

module hold_timer
    import safety_gate_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic step_en,
    input wire logic running,
    input wire logic [TIME_W-1:0] limit,
    // result
    output logic expired
);
    logic [TIME_W-1:0] cnt_q;

    // saturating so a long condition never wraps back to "ok"
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= '0;
        else if (!running)
            cnt_q <= '0;
        else if (step_en && cnt_q != '1)
            cnt_q <= cnt_q + 1'b1;
    end

    // a zero limit switches the check off
    assign expired = (limit != '0) && (cnt_q >= limit);

endmodule : hold_timer

`default_nettype wire

// File: design/safety_gate_monitor.sv
// safety_gate_monitor: door switch monitor with function test and apb settings
// assumes gate inputs and test request are synchronous to pclk
//
// Overview of operation
// - second request before test gives error
// - any error needs gate test before enable
// - test-required output holds until test done
// - five input configurations, default equivalent pair
// - function test selectable, default off
// - per-pair discrepancy time, zero disables check
// - synchronization time setting, zero disables check
// - each optional output individually enabled
// - single and equivalent pair enable rules
// - complementary pair: nc on, no off
// - equivalent two pairs: all four on
// - complementary two pairs: nc on, no off
// - entering run needs gate test first
// - sync error clears after active-inactive-active, after inactive-active with function test off
// - two-pair discrepancy clears after both cycle
`default_nettype none

module safety_gate_monitor
    import safety_gate_pkg::*;
#(
    parameter int SCAN_CYC = SCAN_CYCLES,
    parameter int STEP_CYC = STEP_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // switch contacts and machine request
    input wire logic [3:0] gate_in,
    input wire logic ftest_req,
    // monitor outputs
    output logic out_enable,
    output logic fault_out,
    output logic [1:0] disc_err_out,
    output logic sync_err_out,
    output logic ft_err_out,
    output logic ft_req_out
);
    typedef enum logic [1:0] {GT_IDLE, GT_OPEN, GT_CLOSE} gt_state_t;
    typedef enum logic [1:0] {SC_OFF, SC_ACT, SC_INACT, SC_ACT2} sc_state_t;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic reg_mapped(input logic [7:0] a);
        return a == OFS_CTRL || a == OFS_OUTEN || a == OFS_DISC1 ||
               a == OFS_DISC2 || a == OFS_SYNC || a == OFS_STATUS;
    endfunction : reg_mapped

    function automatic logic is_two(input logic [2:0] t);
        return t == IN_EQV2 || t == IN_CMP2;
    endfunction : is_two

    // returns {active, inactive, mismatch}; unknown codes act as equivalent
    function automatic logic [2:0] pair_eval(input logic [2:0] t, input logic a,
                                             input logic b);
        if (t == IN_SINGLE)
            return {a, ~a, 1'b0};
        else if (t == IN_CMP1 || t == IN_CMP2)
            return {a & ~b, ~a & b, ~(a ^ b)};
        else
            return {a & b, ~a & ~b, a ^ b};
    endfunction : pair_eval

    // ------------------------------------------------------------
    // settings registers
    // ------------------------------------------------------------
    logic [2:0] type_q;
    logic ft_en_q;
    logic run_q;
    logic [5:0] outen_q;
    logic [TIME_W-1:0] disc_time_q [2];
    logic [TIME_W-1:0] sync_time_q;
    logic [31:0] prdata_q;
    logic wr_acc;
    logic scan_en;
    logic step_en;

    assign wr_acc = psel && penable && pwrite;

    // writes take effect in the access phase; status is read-only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            type_q <= IN_EQV1;
            ft_en_q <= 1'b0;
            run_q <= 1'b0;
            outen_q <= OUTEN_RST;
            disc_time_q[0] <= DISC_RST;
            disc_time_q[1] <= DISC_RST;
            sync_time_q <= SYNC_RST;
        end
        else if (wr_acc)
        begin
            unique case (paddr)
                OFS_CTRL:
                begin
                    type_q <= pwdata[CTRL_TYPE_LSB +: 3];
                    ft_en_q <= pwdata[CTRL_FTEST_BIT];
                    run_q <= pwdata[CTRL_RUN_BIT];
                end
                OFS_OUTEN: outen_q <= pwdata[5:0];
                OFS_DISC1: disc_time_q[0] <= pwdata[TIME_W-1:0];
                OFS_DISC2: disc_time_q[1] <= pwdata[TIME_W-1:0];
                OFS_SYNC: sync_time_q <= pwdata[TIME_W-1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // input evaluation
    // ------------------------------------------------------------
    logic [2:0] ev0;
    logic [2:0] ev1;
    logic two;
    logic [1:0] pair_act;
    logic [1:0] pair_mis;
    logic all_act;
    logic all_inact;

    assign ev0 = pair_eval(type_q, gate_in[0], gate_in[1]);
    assign ev1 = pair_eval(type_q, gate_in[2], gate_in[3]);
    assign two = is_two(type_q);
    assign pair_act = {ev1[2], ev0[2]};
    assign pair_mis = {ev1[0] & two, ev0[0]};
    assign all_act = ev0[2] && (!two || ev1[2]);
    assign all_inact = ev0[1] && (!two || ev1[1]);

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    logic [1:0] disc_exp;
    logic sync_exp;
    logic sync_arm_q;
    logic sync_run;

    scan_ticker #(
        .SCAN_CYC(SCAN_CYC),
        .STEP_CYC(STEP_CYC)
    ) u_ticker (
        .pclk(pclk),
        .presetn(presetn),
        .scan_en(scan_en),
        .step_en(step_en)
    );

    // one disagreement timer per pair
    for (genvar i = 0; i < 2; i++)
    begin : g_pair
        hold_timer u_disc (
            .pclk(pclk),
            .presetn(presetn),
            .step_en(step_en),
            .running(run_q && pair_mis[i]),
            .limit(disc_time_q[i]),
            .expired(disc_exp[i])
        );
    end

    // activation spread is timed only after both pairs were seen released,
    // so an opening gate with staggered contacts does not trip it
    assign sync_run = run_q && two && sync_arm_q && (pair_act[0] ^ pair_act[1]);

    hold_timer u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .step_en(step_en),
        .running(sync_run),
        .limit(sync_time_q),
        .expired(sync_exp)
    );

    // ------------------------------------------------------------
    // scan-cycle state
    // ------------------------------------------------------------
    logic run_prev_q;
    logic req_prev_q;
    logic eval;
    logic mode_chg;
    logic mode_run;
    logic req_rise;
    logic [1:0] disc_err_q;
    logic [1:0] disc_set;
    logic disc_clr;
    logic rearm_q;
    logic sync_err_q;
    logic sync_set;
    logic sync_clr;
    sc_state_t sc_q;
    logic ft_err_q;
    logic ft_set;
    logic lock_q;
    logic lock_d;
    logic req_pend_q;
    gt_state_t gt_q;
    logic gt_done;
    logic err_new;
    logic err_any;
    logic oe_q;

    assign eval = scan_en && run_q;
    assign mode_chg = scan_en && (run_q != run_prev_q);
    assign mode_run = mode_chg && run_q;
    assign req_rise = eval && ft_en_q && ftest_req && !req_prev_q;
    assign disc_set = {2{eval}} & disc_exp;
    assign disc_clr = eval && rearm_q && all_act && (pair_mis == 2'b00);
    assign sync_set = eval && sync_exp;
    assign sync_clr = eval && (sc_q == SC_ACT2) && all_act;
    assign ft_set = req_rise && req_pend_q;
    assign err_new = (disc_set != 2'b00) || sync_set || ft_set;
    assign err_any = (disc_err_q != 2'b00) || sync_err_q || ft_err_q;
    assign gt_done = eval && (gt_q == GT_CLOSE) && all_act && !err_new &&
                     (disc_err_q == 2'b00) && !sync_err_q;
    assign lock_d = ft_en_q && ((lock_q && !gt_done) || err_new || mode_run);

    // sampled once per controller cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_prev_q <= 1'b0;
            req_prev_q <= 1'b0;
        end
        else if (scan_en)
        begin
            run_prev_q <= run_q;
            req_prev_q <= ftest_req;
        end
    end

    // discrepancy flags; a new detection wins over a clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            disc_err_q <= '0;
        else
            disc_err_q <= (mode_chg || disc_clr ? 2'b00 : disc_err_q) | disc_set;
    end

    // clear needs every pair released first, both pairs in two-pair modes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rearm_q <= 1'b0;
        else if (mode_chg || disc_clr)
            rearm_q <= 1'b0;
        else if (eval && disc_err_q != 2'b00 && all_inact)
            rearm_q <= 1'b1;
    end

    // arms the spread timer once both pairs have been released
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sync_arm_q <= 1'b0;
        else if (all_inact)
            sync_arm_q <= 1'b1;
        else if (all_act)
            sync_arm_q <= 1'b0;
    end

    // synchronization flag and its release sequence
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_err_q <= 1'b0;
            sc_q <= SC_OFF;
        end
        else if (sync_set)
        begin
            sync_err_q <= 1'b1;
            sc_q <= ft_en_q ? SC_ACT : SC_INACT;
        end
        else if (mode_chg)
        begin
            sync_err_q <= 1'b0;
            sc_q <= SC_OFF;
        end
        else if (eval)
        begin
            if (sync_clr)
                sync_err_q <= 1'b0;
            unique case (sc_q)
                SC_OFF: ;
                SC_ACT: if (all_act) sc_q <= SC_INACT;
                SC_INACT: if (all_inact) sc_q <= SC_ACT2;
                SC_ACT2: if (all_act) sc_q <= SC_OFF;
            endcase
        end
    end

    // function test error and pending request; set wins over the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ft_err_q <= 1'b0;
            req_pend_q <= 1'b0;
        end
        else
        begin
            ft_err_q <= ft_set || (ft_err_q && ft_en_q && !gt_done && !mode_chg);
            req_pend_q <= req_rise || (req_pend_q && ft_en_q && !gt_done && !mode_chg);
        end
    end

    // test lock set by run entry or by any error
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lock_q <= 1'b0;
        else
            lock_q <= lock_d;
    end

    // gate test: wait for open, then for close with no error left
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gt_q <= GT_IDLE;
        else if (mode_chg || !ft_en_q)
            gt_q <= lock_d ? GT_OPEN : GT_IDLE;
        else if (eval)
        begin
            unique case (gt_q)
                GT_IDLE: if (lock_q || req_pend_q) gt_q <= GT_OPEN;
                GT_OPEN: if (all_inact) gt_q <= GT_CLOSE;
                GT_CLOSE:
                begin
                    if (err_new)
                        gt_q <= GT_OPEN;
                    else if (gt_done)
                        gt_q <= GT_IDLE;
                end
                default: gt_q <= GT_IDLE;
            endcase
        end
    end

    // enable changes only at a scan; blocked in the same cycle an error appears
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            oe_q <= 1'b0;
        else if (scan_en)
            oe_q <= run_q && all_act && !err_any && !err_new && !lock_d;
    end

    // ------------------------------------------------------------
    // outputs and read data
    // ------------------------------------------------------------
    logic [31:0] status;

    // optional outputs stay low when not enabled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fault_out <= 1'b0;
            disc_err_out <= '0;
            sync_err_out <= 1'b0;
            ft_err_out <= 1'b0;
            ft_req_out <= 1'b0;
        end
        else
        begin
            fault_out <= err_any && outen_q[EN_FAULT_BIT];
            disc_err_out <= disc_err_q & outen_q[EN_DISC_LSB +: 2];
            sync_err_out <= sync_err_q && outen_q[EN_SYNC_BIT];
            ft_err_out <= ft_err_q && outen_q[EN_FTERR_BIT];
            ft_req_out <= ft_en_q && (lock_q || req_pend_q) && outen_q[EN_FTREQ_BIT];
        end
    end

    always_comb
    begin
        status = '0;
        status[ST_OE_BIT] = oe_q;
        status[ST_FAULT_BIT] = err_any;
        status[ST_DISC_LSB +: 2] = disc_err_q;
        status[ST_SYNC_BIT] = sync_err_q;
        status[ST_FTERR_BIT] = ft_err_q;
        status[ST_FTREQ_BIT] = ft_en_q && (lock_q || req_pend_q);
        status[ST_RUN_BIT] = run_q;
        status[ST_GATE_LSB +: 4] = gate_in;
        status[ST_REQ_BIT] = ftest_req;
    end

    // read data captured in the setup phase so it is stable for the access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= '0;
        else if (psel && !penable)
        begin
            unique case (paddr)
                OFS_CTRL: prdata_q <= {27'h0, run_q, ft_en_q, type_q};
                OFS_OUTEN: prdata_q <= {26'h0, outen_q};
                OFS_DISC1: prdata_q <= {20'h0, disc_time_q[0]};
                OFS_DISC2: prdata_q <= {20'h0, disc_time_q[1]};
                OFS_SYNC: prdata_q <= {20'h0, sync_time_q};
                OFS_STATUS: prdata_q <= status;
                default: prdata_q <= '0;
            endcase
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !reg_mapped(paddr);
    assign out_enable = oe_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_second_req;
        req_rise && req_pend_q;
    endsequence
    sequence s_enter_run;
        mode_chg && run_q && ft_en_q;
    endsequence

    a_oe_single_in: assert property (scan_en && type_q == IN_SINGLE && !gate_in[0]
        |=> !out_enable) else $error("enable with single input off");
    a_oe_cmp_pair: assert property (scan_en && type_q == IN_CMP1 &&
        (!gate_in[0] || gate_in[1]) |=> !out_enable) else $error("cmp pair enable");
    a_oe_eqv_two: assert property (scan_en && type_q == IN_EQV2 && gate_in != 4'hf
        |=> !out_enable) else $error("eqv two pair enable");
    a_oe_cmp_two: assert property (scan_en && type_q == IN_CMP2 && gate_in != 4'h5
        |=> !out_enable) else $error("cmp two pair enable");
    a_err_safe_state: assert property (err_any && outen_q[EN_FAULT_BIT]
        |-> !out_enable ##1 fault_out) else $error("error without safe state");
    a_ft_err_raise: assert property (s_second_req |=> ft_err_q && !out_enable)
        else $error("second request without test error");
    a_test_req_hold: assert property (lock_q && !gt_done && ft_en_q
        |=> lock_q) else $error("test lock released without test");
    a_start_lock: assert property (s_enter_run |=> lock_q [*2])
        else $error("run entry without test lock");
    a_lock_blocks_oe: assert property (lock_q |-> !out_enable)
        else $error("enable while test pending");
    a_disc_detect: assert property (eval && disc_exp[0] |=> disc_err_q[0])
        else $error("pair discrepancy missed");
    a_disc_zero_off: assert property (disc_time_q[1] == '0 |-> !disc_exp[1])
        else $error("zero discrepancy time still checks");
    a_disc_rearm: assert property ($fell(disc_err_q != 2'b00)
        |-> $past(rearm_q) || $past(mode_chg)) else $error("discrepancy cleared early");
    a_sync_detect: assert property (eval && sync_exp |=> sync_err_q)
        else $error("sync error missed");
    a_sync_clear_seq: assert property ($fell(sync_err_q)
        |-> $past(sc_q == SC_ACT2) || $past(mode_chg)) else $error("sync cleared early");

endmodule : safety_gate_monitor

`default_nettype wire

// File: tb/gate_switch_model.sv
// gate_switch_model: door switch contacts as the monitor sees them
// assumes the bench changes its commands just after a rising pclk edge
`default_nettype none

module gate_switch_model (
    // clock
    input wire logic pclk,
    // commands from the bench
    input wire logic closed,
    input wire logic cmp,
    input wire logic [3:0] flip,
    // contacts, high = on
    output logic [3:0] gate_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // contacts move only on a clock edge, so they are never sampled mid-change
    // nc contacts on and no contacts off when closed; flip inverts the chosen contacts
    always @(posedge pclk)
    begin
        gate_in <= (closed ? (cmp ? 4'h5 : 4'hf) : (cmp ? 4'ha : 4'h0)) ^ flip;
    end
endmodule : gate_switch_model

`default_nettype wire

// File: tb/safety_gate_monitor_bench.sv
// safety_gate_monitor_bench: self-checking bench for the gate monitor
// assumes shortened scan and step counts and an apb slave with no wait state
`default_nettype none

module safety_gate_monitor_bench import safety_gate_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] gate_in, flip;
    logic ftest_req, closed, cmp, out_enable, fault_out, sync_err_out, ft_err_out, ft_req_out;
    logic [1:0] disc_err_out;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    // rows: mode, contact flips, expected enable with the gate closed
    localparam logic [7:0] ROWS [10] = '{8'h01, 8'h02, 8'h21, 8'h24, 8'h41,
                                         8'h44, 8'h61, 8'h70, 8'h81, 8'h88};

    safety_gate_monitor #(.SCAN_CYC(4), .STEP_CYC(8)) i_safety_gate_monitor (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gate_in(gate_in), .ftest_req(ftest_req), .out_enable(out_enable),
        .fault_out(fault_out), .disc_err_out(disc_err_out), .sync_err_out(sync_err_out),
        .ft_err_out(ft_err_out), .ft_req_out(ft_req_out));
    gate_switch_model i_gate_switch_model (.pclk(pclk), .closed(closed), .cmp(cmp),
        .flip(flip), .gate_in(gate_in));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial pclk = 1'b0;
    always #20 pclk = ~pclk;

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            end_of_test();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    // one apb transfer; request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rd, err);
        chk(rd, exp);
    endtask : rdchk

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {presetn, psel, penable, pwrite, ftest_req, closed, cmp} = '0;
        paddr = '0;
        pwdata = '0;
        flip = '0;
        cyc(10);
        presetn <= 1'b1;
        chk(out_enable, 1'b0);
        rdchk(OFS_CTRL, 32'h1);
        rdchk(OFS_OUTEN, 32'h3f);
        rdchk(OFS_DISC1, 32'h3);
        rdchk(OFS_DISC2, 32'h3);
        rdchk(OFS_SYNC, 32'h1e);
        apb(1'b0, 8'h18, 32'h0, rd, err);
        chk(rd, 32'h0);
        chk(err, 1'b1);
        $display("reset values done");
        // checks off so mismatched rows show only the combining logic
        apb(1'b1, OFS_DISC1, 32'h0, rd, err);
        apb(1'b1, OFS_DISC2, 32'h0, rd, err);
        apb(1'b1, OFS_SYNC, 32'h0, rd, err);
        foreach (ROWS[i])
        begin
            apb(1'b1, OFS_CTRL, {27'h0, 2'h2, ROWS[i][7:5]}, rd, err);
            cmp <= (ROWS[i][7:5] == 3'h2) || (ROWS[i][7:5] == 3'h4);
            flip <= ROWS[i][4:1];
            closed <= 1'b1;
            cyc(12);
            chk(out_enable, ROWS[i][0]);
        end
        $display("input types done");
        // pair one disagrees beyond two steps
        apb(1'b1, OFS_DISC1, 32'h2, rd, err);
        apb(1'b1, OFS_CTRL, 32'h11, rd, err);
        cmp <= 1'b0;
        flip <= 4'h0;
        cyc(12);
        flip <= 4'h2;
        cyc(40);
        chk({disc_err_out, fault_out, out_enable}, 4'h6);
        apb(1'b1, OFS_OUTEN, 32'h3c, rd, err);
        cyc(2);
        chk(disc_err_out, 2'h0);
        rdchk(OFS_STATUS, {19'h0, 1'b0, 4'hd, 8'h86});
        apb(1'b1, OFS_OUTEN, 32'h3f, rd, err);
        $display("discrepancy done");
        // function test: idle to run needs a gate test first
        flip <= 4'h0;
        apb(1'b1, OFS_CTRL, 32'h09, rd, err);
        // idle must last past one scan, or the run entry is never seen
        cyc(4);
        apb(1'b1, OFS_CTRL, 32'h19, rd, err);
        cyc(12);
        chk({ft_req_out, out_enable}, 2'h2);
        closed <= 1'b0;
        cyc(12);
        closed <= 1'b1;
        cyc(12);
        chk({ft_req_out, out_enable}, 2'h1);
        ftest_req <= 1'b1;
        cyc(12);
        chk({ft_req_out, out_enable}, 2'h3);
        ftest_req <= 1'b0;
        cyc(12);
        ftest_req <= 1'b1;
        cyc(12);
        chk({ft_err_out, fault_out, out_enable}, 3'h6);
        ftest_req <= 1'b0;
        closed <= 1'b0;
        cyc(12);
        closed <= 1'b1;
        cyc(12);
        chk({ft_err_out, out_enable}, 2'h1);
        $display("function test done");
        // two pairs, test off: pair two closing late trips the spread timer
        apb(1'b1, OFS_CTRL, 32'h13, rd, err);
        apb(1'b1, OFS_SYNC, 32'h2, rd, err);
        closed <= 1'b0;
        cyc(12);
        closed <= 1'b1;
        flip <= 4'hc;
        cyc(40);
        chk({sync_err_out, fault_out, out_enable}, 3'h6);
        flip <= 4'h0;
        closed <= 1'b0;
        cyc(12);
        closed <= 1'b1;
        cyc(12);
        chk({sync_err_out, out_enable}, 2'h1);
        $display("synchronization done");
        // pair one fault holds until both pairs were released together
        flip <= 4'h1;
        cyc(40);
        flip <= 4'h3;
        cyc(12);
        flip <= 4'h0;
        cyc(12);
        chk({disc_err_out, out_enable}, 3'h2);
        closed <= 1'b0;
        cyc(12);
        closed <= 1'b1;
        cyc(12);
        chk({disc_err_out, out_enable}, 3'h1);
        $display("pair release done");
        end_of_test();
    end
endmodule : safety_gate_monitor_bench

`default_nettype wire
